// ### hw/ctr_pkg.sv
/*
 * Constants for the five-counter gating and command decode block.
 * Assumes the user includes this package before the design modules.
 */
`default_nettype none
package ctr_pkg;
    localparam int NUM_CTR = 5;
    localparam int CNT_W = 16;
    // --------------------------------------------------------------
    // Counter mode setup field positions
    // --------------------------------------------------------------
    localparam int MODE_REPEAT_BIT = 5;
    localparam int MODE_RELOAD_ALT_BIT = 6;
    localparam int MODE_RETRIG_BIT = 7;
    localparam int MODE_SRC_LO = 8;
    localparam int MODE_SRC_HI = 11;
    localparam int MODE_POL_BIT = 12;
    localparam int MODE_GATE_LO = 13;
    localparam int MODE_GATE_HI = 15;
    localparam logic [15:0] MODE_RESET = 16'h0000;
    // --------------------------------------------------------------
    // Gating codes
    // --------------------------------------------------------------
    localparam logic [2:0] GATE_NONE = 3'h0;
    localparam logic [2:0] GATE_LOWER_TC = 3'h1;
    localparam logic [2:0] GATE_NEXT_HI = 3'h2;
    localparam logic [2:0] GATE_NEXT_LO = 3'h3;
    localparam logic [2:0] GATE_OWN_HI = 3'h4;
    localparam logic [2:0] GATE_OWN_LO = 3'h5;
    localparam logic [2:0] GATE_EDGE_HI = 3'h6;
    localparam logic [2:0] GATE_EDGE_LO = 3'h7;
    // --------------------------------------------------------------
    // Source select ranges
    // --------------------------------------------------------------
    localparam logic [3:0] SRC_LOWER_TC = 4'h0;
    localparam logic [3:0] SRC_PIN_BASE = 4'h1;
    localparam logic [3:0] SRC_GATE_BASE = 4'h6;
    localparam logic [3:0] SRC_TAP_BASE = 4'hB;
    // --------------------------------------------------------------
    // Command opcodes
    // --------------------------------------------------------------
    localparam logic [2:0] OP_POINTER = 3'h0;
    localparam logic [2:0] OP_ARM = 3'h1;
    localparam logic [2:0] OP_LOAD = 3'h2;
    localparam logic [2:0] OP_LOAD_ARM = 3'h3;
    localparam logic [2:0] OP_DISARM_SAVE = 3'h4;
    localparam logic [2:0] OP_SAVE = 3'h5;
    localparam logic [2:0] OP_DISARM = 3'h6;
    localparam logic [2:0] OP_SINGLE = 3'h7;
    localparam logic [1:0] SUB_CLEAR = 2'h0;
    localparam logic [1:0] SUB_SET = 2'h1;
    localparam logic [1:0] SUB_STEP = 2'h2;
    localparam logic [1:0] SUB_MISC = 2'h3;
    localparam logic [2:0] NUM_POINTER_SEQ = 3'h0;
    localparam logic [2:0] NUM_FREQ_OUT = 3'h6;
    localparam logic [2:0] NUM_WIDE_BUS = 3'h7;
    localparam logic [7:0] CMD_PREFETCH_ON = 8'hF8;
    localparam logic [7:0] CMD_PREFETCH_OFF = 8'hF9;
    localparam logic [7:0] CMD_MASTER_RESET = 8'hFF;
    localparam logic [2:0] PTR_GROUP_BAD_A = 3'h0;
    localparam logic [2:0] PTR_GROUP_BAD_B = 3'h6;
endpackage
`default_nettype wire

// ### hw/ctr_slice.sv
/*
 * One 16-bit down counter with load/hold registers, retrigger,
 * gating and reload logic.
 * Assumes qualified events arrive as one-cycle strobes on CLK_I.
 */
`default_nettype none
module ctr_slice #(
    parameter int CNT_W = 16
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic en_i,
    input wire logic [15:0] mode_i,
    input wire logic [CNT_W-1:0] load_val_i,
    input wire logic src_edge_i,
    input wire logic gate_ok_i,
    input wire logic gate_act_edge_i,
    input wire logic own_gate_i,
    input wire logic arm_i,
    input wire logic disarm_i,
    input wire logic load_i,
    input wire logic save_i,
    input wire logic step_i,
    input wire logic tog_set_i,
    input wire logic tog_clr_i,
    output logic [CNT_W-1:0] count_o,
    output logic [CNT_W-1:0] hold_o,
    output logic tc_o,
    output logic tog_o,
    output logic armed_o
);
    logic [CNT_W-1:0] count_q, count_d, hold_q, hold_d, reload;
    logic armed_q, armed_d, retrig_q, retrig_d, tog_q, tog_d;
    logic tc_q, tc_d, run_q, run_d, tick, edge_mode, gated;
    logic [2:0] gm;
    always_comb begin
        gm = mode_i[ctr_pkg::MODE_GATE_HI:ctr_pkg::MODE_GATE_LO];
        edge_mode = gm[2] & gm[1];
        gated = gm != ctr_pkg::GATE_NONE;
        // Gate picks reload source only when ungated
        reload = load_val_i;
        if (!gated && mode_i[ctr_pkg::MODE_RETRIG_BIT] &&
            mode_i[ctr_pkg::MODE_RELOAD_ALT_BIT] && own_gate_i) begin
            reload = hold_q; // RQ6
        end
        count_d = count_q;
        hold_d = hold_q;
        armed_d = armed_q;
        retrig_d = retrig_q;
        tog_d = tog_q;
        tc_d = 1'b0;
        run_d = run_q;
        // Edge gating runs once started
        tick = (src_edge_i && armed_q &&
                (edge_mode ? run_q : gate_ok_i)) || step_i; // RQ3 RQ25
        if (save_i) begin
            hold_d = count_q;
        end
        if ((tick || load_i) && retrig_q) begin
            count_d = load_val_i; // RQ2 RQ4
            retrig_d = 1'b0;
        end else if (load_i) begin
            count_d = reload;
        end else if (tick) begin
            if (count_q == CNT_W'(1)) begin
                count_d = reload; // RQ23
                tc_d = 1'b1;
                tog_d = ~tog_q;
                if (!mode_i[ctr_pkg::MODE_REPEAT_BIT]) begin
                    armed_d = 1'b0; // RQ24
                end
                if (edge_mode) begin
                    run_d = 1'b0;
                end
            end else begin
                count_d = count_q - CNT_W'(1);
            end
        end
        // Set after the clears, so a gate edge with repeat on is never lost; without repeat it is ignored while run is set
        if (edge_mode && gate_act_edge_i &&
            (mode_i[ctr_pkg::MODE_REPEAT_BIT] || !run_q)) begin
            run_d = 1'b1; // RQ12 RQ13
        end
        if (gated && mode_i[ctr_pkg::MODE_RETRIG_BIT] &&
            gate_act_edge_i) begin
            hold_d = count_q; // RQ1 RQ5
            retrig_d = 1'b1;
        end
        if (disarm_i) begin
            armed_d = 1'b0;
        end
        if (arm_i) begin
            armed_d = 1'b1;
        end
        if (tog_set_i) begin
            tog_d = 1'b1;
        end else if (tog_clr_i) begin
            tog_d = 1'b0;
        end
    end
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            count_q <= '0;
            hold_q <= '0;
            armed_q <= 1'b0;
            retrig_q <= 1'b0;
            tog_q <= 1'b0;
            tc_q <= 1'b0;
            run_q <= 1'b0;
        end else if (en_i) begin
            count_q <= count_d;
            hold_q <= hold_d;
            armed_q <= armed_d;
            retrig_q <= retrig_d;
            tog_q <= tog_d;
            tc_q <= tc_d;
            run_q <= run_d;
        end
    end
    assign count_o = count_q;
    assign hold_o = hold_q;
    assign tc_o = tc_q;
    assign tog_o = tog_q;
    assign armed_o = armed_q;
endmodule
`default_nettype wire

// ### hw/ctr_gate_cmd.sv
/*
 * Top of the five-counter gating, source selection and command decode.
 * Assumes pins are asynchronous to CLK_I and the host writes commands
 * and mode words synchronously with a one-cycle strobe.
 */
// Overview of operation
// RQ1 - Retrigger gate edge saves count into hold
// RQ2 - First qualified edge after retrigger loads counter
// RQ3 - Qualified edge needs armed and gated on
// RQ4 - Load or step after retrigger acts as edge
// RQ5 - Retrigger bit enables retrigger when gating selected
// RQ6 - Ungated retrigger bit lets gate pick reload
// RQ7 - Polarity bit picks rising or falling source
// RQ8 - Four-bit select picks one of sixteen sources
// RQ9 - Code 000 counts whenever armed
// RQ10 - Codes 100/101 own gate high/low level
// RQ11 - Codes 010/011 use neighbour gate pins
// RQ12 - Codes 110/111 start counting on gate edge
// RQ13 - Repeat edge gating restarts after terminal count
// RQ14 - Code 001 gates by lower terminal count
// RQ15 - Host writes each command as one byte
// RQ16 - Host never writes unassigned command codes
// RQ17 - Group commands act on each selected counter
// RQ18 - Single commands address counters one to five
// RQ19 - Pointer opcode loads element and group fields
// RQ20 - Top bits select arm, load, save, disarm
// RQ21 - Set, clear toggle and step single counter
// RQ22 - Master mode bit commands and master reset
// RQ23 - Terminal count reloads from load or hold
// RQ24 - Repeat bit clear disarms after one cycle
// RQ25 - Step applies exactly one count
`default_nettype none
module ctr_gate_cmd #(
    parameter int NUM_CTR = ctr_pkg::NUM_CTR,
    parameter int CNT_W = ctr_pkg::CNT_W
) (
    input wire logic CLK_I,
    input wire logic RST_B_I,
    input wire logic CE_I,
    input wire logic CMD_WR_I,
    input wire logic [7:0] CMD_DATA_I,
    input wire logic MODE_WR_I,
    input wire logic [2:0] MODE_SEL_I,
    input wire logic [15:0] MODE_DATA_I,
    input wire logic LOAD_WR_I,
    input wire logic [CNT_W-1:0] LOAD_DATA_I,
    input wire logic [NUM_CTR-1:0] COUNT_SOURCE_PIN_I,
    input wire logic [NUM_CTR-1:0] COUNTER_GATE_PIN_I,
    input wire logic [NUM_CTR-1:0] FREQ_TAP_I,
    output logic [NUM_CTR*CNT_W-1:0] COUNT_O,
    output logic [NUM_CTR*CNT_W-1:0] HOLD_O,
    output logic [NUM_CTR-1:0] TERMINAL_COUNT_O,
    output logic [NUM_CTR-1:0] TOGGLE_O,
    output logic [NUM_CTR-1:0] ARMED_O,
    output logic [1:0] POINTER_ELEMENT_FIELD_O,
    output logic [2:0] POINTER_GROUP_FIELD_O,
    output logic POINTER_SEQUENCING_DISABLE_O,
    output logic FREQ_OUT_GATE_OFF_O,
    output logic WIDE_BUS_SELECT_O,
    output logic PREFETCH_ENABLE_O
);
    // --------------------------------------------------------------
    // Reset release and pin synchronisers
    // --------------------------------------------------------------
    logic [1:0] rst_sync_q;
    logic rst_b;
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_b = rst_sync_q[1];

    localparam int NPIN = 3 * NUM_CTR;
    logic [NPIN-1:0] pin_raw, s1_q, s2_q, s3_q, pin_lvl_q, pin_lvl_d;
    assign pin_raw = {FREQ_TAP_I, COUNTER_GATE_PIN_I, COUNT_SOURCE_PIN_I};
    always_comb begin
        pin_lvl_d = pin_lvl_q;
        for (int i = 0; i < NPIN; i++) begin
            if (s2_q[i] == s3_q[i]) begin
                pin_lvl_d[i] = s2_q[i];
            end
        end
    end
    always_ff @(posedge CLK_I or negedge rst_b) begin
        if (!rst_b) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            pin_lvl_q <= '0;
        end else if (CE_I) begin
            s1_q <= pin_raw;
            s2_q <= s1_q;
            s3_q <= s2_q;
            pin_lvl_q <= pin_lvl_d;
        end
    end
    logic [NUM_CTR-1:0] src_lvl, gate_lvl, tap_lvl;
    assign src_lvl = pin_lvl_q[NUM_CTR-1:0];
    assign gate_lvl = pin_lvl_q[2*NUM_CTR-1:NUM_CTR];
    assign tap_lvl = pin_lvl_q[NPIN-1:2*NUM_CTR];

    // --------------------------------------------------------------
    // Command and mode registers
    // --------------------------------------------------------------
    logic [15:0] mode_q [NUM_CTR];
    logic [15:0] mode_d [NUM_CTR];
    logic [CNT_W-1:0] load_q [NUM_CTR];
    logic [CNT_W-1:0] load_d [NUM_CTR];
    logic [1:0] elem_q, elem_d;
    logic [2:0] group_q, group_d;
    logic seq_dis_q, seq_dis_d, divided_frequency_output_off_q, divided_frequency_output_off_d;
    logic wide_q, wide_d, pref_q, pref_d, mreset;
    logic [2:0] op, num;
    logic [1:0] sub;
    logic [NUM_CTR-1:0] sel, nsel;
    logic [NUM_CTR-1:0] c_arm, c_dis, c_load, c_save, c_step, c_set, c_clr;

    always_comb begin
        op = CMD_DATA_I[7:5];
        sub = CMD_DATA_I[4:3];
        num = CMD_DATA_I[2:0];
        sel = CMD_WR_I ? CMD_DATA_I[NUM_CTR-1:0] : '0; // RQ15 RQ17
        nsel = '0;
        for (int i = 0; i < NUM_CTR; i++) begin
            nsel[i] = CMD_WR_I && op == ctr_pkg::OP_SINGLE &&
                      num == 3'(i + 1); // RQ18
        end
        c_arm = (op == ctr_pkg::OP_ARM || op == ctr_pkg::OP_LOAD_ARM)
                ? sel : '0; // RQ20
        c_load = (op == ctr_pkg::OP_LOAD || op == ctr_pkg::OP_LOAD_ARM)
                ? sel : '0;
        c_dis = (op == ctr_pkg::OP_DISARM || op == ctr_pkg::OP_DISARM_SAVE)
                ? sel : '0;
        c_save = (op == ctr_pkg::OP_SAVE || op == ctr_pkg::OP_DISARM_SAVE)
                ? sel : '0;
        c_set = sub == ctr_pkg::SUB_SET ? nsel : '0; // RQ21
        c_clr = sub == ctr_pkg::SUB_CLEAR ? nsel : '0;
        c_step = sub == ctr_pkg::SUB_STEP ? nsel : '0;
        mreset = CMD_WR_I && CMD_DATA_I == ctr_pkg::CMD_MASTER_RESET;
        elem_d = elem_q;
        group_d = group_q;
        // Reserved groups ignored
        if (CMD_WR_I && op == ctr_pkg::OP_POINTER &&
            num != ctr_pkg::PTR_GROUP_BAD_A &&
            num != ctr_pkg::PTR_GROUP_BAD_B) begin
            elem_d = CMD_DATA_I[4:3]; // RQ19
            group_d = num;
        end
        seq_dis_d = seq_dis_q;
        divided_frequency_output_off_d = divided_frequency_output_off_q;
        wide_d = wide_q;
        pref_d = pref_q;
        if (CMD_WR_I && op == ctr_pkg::OP_SINGLE &&
            (sub == ctr_pkg::SUB_SET || sub == ctr_pkg::SUB_CLEAR)) begin
            case (num)
                ctr_pkg::NUM_POINTER_SEQ: seq_dis_d = sub[0]; // RQ22
                ctr_pkg::NUM_FREQ_OUT: divided_frequency_output_off_d = sub[0];
                ctr_pkg::NUM_WIDE_BUS: wide_d = sub[0];
                default: ;
            endcase
        end
        if (CMD_WR_I && CMD_DATA_I == ctr_pkg::CMD_PREFETCH_ON) begin
            pref_d = 1'b1;
        end
        if (CMD_WR_I && CMD_DATA_I == ctr_pkg::CMD_PREFETCH_OFF) begin
            pref_d = 1'b0;
        end
        for (int i = 0; i < NUM_CTR; i++) begin
            mode_d[i] = mode_q[i];
            load_d[i] = load_q[i];
            if (MODE_WR_I && MODE_SEL_I == 3'(i + 1)) begin
                mode_d[i] = MODE_DATA_I;
            end
            if (LOAD_WR_I && MODE_SEL_I == 3'(i + 1)) begin
                load_d[i] = LOAD_DATA_I;
            end
        end
    end
    always_ff @(posedge CLK_I or negedge rst_b) begin
        if (!rst_b) begin
            elem_q <= '0;
            group_q <= '0;
            seq_dis_q <= 1'b0;
            divided_frequency_output_off_q <= 1'b0;
            wide_q <= 1'b0;
            pref_q <= 1'b0;
            for (int i = 0; i < NUM_CTR; i++) begin
                mode_q[i] <= ctr_pkg::MODE_RESET;
                load_q[i] <= '0;
            end
        end else if (CE_I) begin
            if (mreset) begin
                elem_q <= '0;
                group_q <= '0;
                seq_dis_q <= 1'b0;
                divided_frequency_output_off_q <= 1'b0;
                wide_q <= 1'b0;
                pref_q <= 1'b0;
                for (int i = 0; i < NUM_CTR; i++) begin
                    mode_q[i] <= ctr_pkg::MODE_RESET;
                    load_q[i] <= '0;
                end
            end else begin
                elem_q <= elem_d;
                group_q <= group_d;
                seq_dis_q <= seq_dis_d;
                divided_frequency_output_off_q <= divided_frequency_output_off_d;
                wide_q <= wide_d;
                pref_q <= pref_d;
                mode_q <= mode_d;
                load_q <= load_d;
            end
        end
    end

    // --------------------------------------------------------------
    // Per-counter source and gate selection
    // --------------------------------------------------------------
    logic [NUM_CTR-1:0] tc, src_prev_q, gate_prev_q;
    genvar g;
    generate
        for (g = 0; g < NUM_CTR; g++) begin : gen_ctr
            localparam int LO = (g + NUM_CTR - 1) % NUM_CTR;
            localparam int HI = (g + 1) % NUM_CTR;
            logic [15:0] m;
            logic [3:0] ssel;
            logic [2:0] gm;
            logic src_lvl_sel, src_lvl_pol, src_edge, gate_ok, act_lvl;
            logic gate_edge;
            assign m = mode_q[g];
            assign ssel = m[ctr_pkg::MODE_SRC_HI:ctr_pkg::MODE_SRC_LO];
            assign gm = m[ctr_pkg::MODE_GATE_HI:ctr_pkg::MODE_GATE_LO];
            always_comb begin
                // Lower terminal count feeds as a level pulse
                src_lvl_sel = tc[LO]; // RQ8
                if (ssel >= ctr_pkg::SRC_TAP_BASE) begin
                    src_lvl_sel = tap_lvl[3'(ssel - ctr_pkg::SRC_TAP_BASE)];
                end else if (ssel >= ctr_pkg::SRC_GATE_BASE) begin
                    src_lvl_sel = gate_lvl[3'(ssel - ctr_pkg::SRC_GATE_BASE)];
                end else if (ssel >= ctr_pkg::SRC_PIN_BASE) begin
                    src_lvl_sel = src_lvl[3'(ssel - ctr_pkg::SRC_PIN_BASE)];
                end
                src_lvl_pol = src_lvl_sel ^ m[ctr_pkg::MODE_POL_BIT]; // RQ7
                case (gm)
                    ctr_pkg::GATE_NONE: gate_ok = 1'b1; // RQ9
                    ctr_pkg::GATE_LOWER_TC: gate_ok = tc[LO]; // RQ14
                    ctr_pkg::GATE_NEXT_HI: gate_ok = gate_lvl[HI]; // RQ11
                    ctr_pkg::GATE_NEXT_LO: gate_ok = gate_lvl[LO];
                    ctr_pkg::GATE_OWN_HI: gate_ok = gate_lvl[g]; // RQ10
                    ctr_pkg::GATE_OWN_LO: gate_ok = ~gate_lvl[g];
                    default: gate_ok = 1'b1; // RQ12
                endcase
                act_lvl = (gm == ctr_pkg::GATE_OWN_LO ||
                           gm == ctr_pkg::GATE_EDGE_LO) ? ~gate_lvl[g] :
                          (gm == ctr_pkg::GATE_NEXT_HI) ? gate_lvl[HI] :
                          (gm == ctr_pkg::GATE_NEXT_LO) ? gate_lvl[LO] :
                          (gm == ctr_pkg::GATE_LOWER_TC) ? tc[LO] :
                          gate_lvl[g];
            end
            assign src_edge = src_lvl_pol && !src_prev_q[g];
            assign gate_edge = act_lvl && !gate_prev_q[g];
            always_ff @(posedge CLK_I or negedge rst_b) begin
                if (!rst_b) begin
                    src_prev_q[g] <= 1'b1;
                    gate_prev_q[g] <= 1'b1;
                end else if (CE_I) begin
                    src_prev_q[g] <= src_lvl_pol;
                    gate_prev_q[g] <= act_lvl;
                end
            end
            ctr_slice #(
                .CNT_W(CNT_W)
            ) u_slice (
                .clk_i(CLK_I),
                .rst_b_i(rst_b),
                .en_i(CE_I),
                .mode_i(m),
                .load_val_i(load_q[g]),
                .src_edge_i(src_edge),
                .gate_ok_i(gate_ok),
                .gate_act_edge_i(gate_edge),
                .own_gate_i(gate_lvl[g]),
                .arm_i(c_arm[g]),
                .disarm_i(c_dis[g]),
                .load_i(c_load[g]),
                .save_i(c_save[g]),
                .step_i(c_step[g]),
                .tog_set_i(c_set[g]),
                .tog_clr_i(c_clr[g]),
                .count_o(COUNT_O[g*CNT_W +: CNT_W]),
                .hold_o(HOLD_O[g*CNT_W +: CNT_W]),
                .tc_o(tc[g]),
                .tog_o(TOGGLE_O[g]),
                .armed_o(ARMED_O[g])
            );
        end
    endgenerate
    assign TERMINAL_COUNT_O = tc;
    assign POINTER_ELEMENT_FIELD_O = elem_q;
    assign POINTER_GROUP_FIELD_O = group_q;
    assign POINTER_SEQUENCING_DISABLE_O = seq_dis_q;
    assign FREQ_OUT_GATE_OFF_O = divided_frequency_output_off_q;
    assign WIDE_BUS_SELECT_O = wide_q;
    assign PREFETCH_ENABLE_O = pref_q;
endmodule
`default_nettype wire

// ### verification/ctr_gate_cmd_asserts.sv
/* Checker on the top ports of the gating and command decode block.
   Assumes one clock domain and the bind at the foot of this file. */
`default_nettype none
module ctr_gate_cmd_asserts #(
    parameter int NUM_CTR = 5,
    parameter int CNT_W = 16
) (
    input wire logic CLK_I,
    input wire logic RST_B_I,
    input wire logic CE_I,
    input wire logic CMD_WR_I,
    input wire logic [7:0] CMD_DATA_I,
    input wire logic [NUM_CTR*CNT_W-1:0] COUNT_O,
    input wire logic [NUM_CTR*CNT_W-1:0] HOLD_O,
    input wire logic [NUM_CTR-1:0] TOGGLE_O,
    input wire logic [NUM_CTR-1:0] ARMED_O,
    input wire logic [1:0] POINTER_ELEMENT_FIELD_O,
    input wire logic [2:0] POINTER_GROUP_FIELD_O,
    input wire logic POINTER_SEQUENCING_DISABLE_O,
    input wire logic FREQ_OUT_GATE_OFF_O,
    input wire logic WIDE_BUS_SELECT_O,
    input wire logic PREFETCH_ENABLE_O
);
    logic cmd;
    logic [7:0] cq;
    assign cmd = CE_I && CMD_WR_I;
    // Command data bus one cycle back
    always_ff @(posedge CLK_I) begin
        cq <= CMD_DATA_I;
    end
    default clocking @(posedge CLK_I);
    endclocking
    default disable iff (!RST_B_I);
    a_arm_sets_armed: assert property (
        cmd && CMD_DATA_I[7:5] == 3'h1 |=> (ARMED_O & cq[4:0]) == cq[4:0])
        else $error("arm missed");
    a_freq_gate_bit: assert property (
        cmd && CMD_DATA_I inside {8'hEE, 8'hE6}
        |=> FREQ_OUT_GATE_OFF_O == cq[3])
        else $error("divided_frequency_output bit wrong");
    a_bus_width_bit: assert property (
        cmd && CMD_DATA_I inside {8'hEF, 8'hE7}
        |=> WIDE_BUS_SELECT_O == cq[3])
        else $error("bus bit wrong");
    a_ptr_seq_bit: assert property (
        cmd && CMD_DATA_I inside {8'hE8, 8'hE0}
        |=> POINTER_SEQUENCING_DISABLE_O == cq[3])
        else $error("seq bit wrong");
    a_prefetch_bit: assert property (
        cmd && CMD_DATA_I inside {8'hF8, 8'hF9}
        |=> PREFETCH_ENABLE_O != cq[0])
        else $error("prefetch bit wrong");
    a_pointer_load: assert property (
        cmd && CMD_DATA_I[7:5] == 3'h0 &&
        !(CMD_DATA_I[2:0] inside {3'h0, 3'h6})
        |=> {POINTER_ELEMENT_FIELD_O, POINTER_GROUP_FIELD_O} == cq[4:0])
        else $error("pointer missed");
    a_toggle_set: assert property (
        cmd && CMD_DATA_I[7:3] == 5'h1D && CMD_DATA_I[2:0] inside {[1:5]}
        |=> TOGGLE_O[cq[2:0] - 3'h1])
        else $error("toggle not set");
    a_save_hold: assert property (
        cmd && CMD_DATA_I[7:5] == 3'h5 && CMD_DATA_I[0]
        |=> HOLD_O[CNT_W-1:0] == $past(COUNT_O[CNT_W-1:0]))
        else $error("save missed");
endmodule
bind ctr_gate_cmd ctr_gate_cmd_asserts #(.NUM_CTR(NUM_CTR), .CNT_W(CNT_W))
u_chk (.CLK_I(CLK_I), .RST_B_I(RST_B_I), .CE_I(CE_I), .CMD_WR_I(CMD_WR_I),
    .CMD_DATA_I(CMD_DATA_I), .COUNT_O(COUNT_O), .HOLD_O(HOLD_O),
    .TOGGLE_O(TOGGLE_O), .ARMED_O(ARMED_O),
    .POINTER_ELEMENT_FIELD_O(POINTER_ELEMENT_FIELD_O),
    .POINTER_GROUP_FIELD_O(POINTER_GROUP_FIELD_O),
    .POINTER_SEQUENCING_DISABLE_O(POINTER_SEQUENCING_DISABLE_O),
    .FREQ_OUT_GATE_OFF_O(FREQ_OUT_GATE_OFF_O),
    .WIDE_BUS_SELECT_O(WIDE_BUS_SELECT_O),
    .PREFETCH_ENABLE_O(PREFETCH_ENABLE_O));
`default_nettype wire

// ### verification/host_model.sv
/* Host side: writes one command byte at a time to the control port.
   Assumes the bench calls send only after reset has settled. */
`default_nettype none
module host_model (
    input wire logic clk_i,
    output logic cmd_wr_o,
    output logic [7:0] cmd_data_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        cmd_wr_o = 1'b0;
        cmd_data_o = 8'h00;
    end
    task automatic send(input logic [7:0] b);
        if (b[7:3] == 5'h1F && !(b inside {8'hF8, 8'hF9, 8'hFF}))
            return;
        if (b[7:5] == 3'h0 && b[2:0] inside {3'h0, 3'h6})
            return;
        @(posedge clk_i);
        cmd_wr_o <= 1'b1;
        cmd_data_o <= b;
        @(posedge clk_i);
        cmd_wr_o <= 1'b0;
        // Released bus shows no stale byte
        cmd_data_o <= ~b;
    endtask
endmodule
`default_nettype wire

// ### verification/tb.sv
/* Self-checking bench for the gating and command decode block.
   Assumes the host model issues commands; counter 1 gets pin stimulus. */
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int W = ctr_pkg::CNT_W;
    logic clk, rst_b, ce, cmd_wr, mode_wr, load_wr, psd, fog, wbs, pfe;
    logic [7:0] cmd_data;
    logic [2:0] mode_sel, pg;
    logic [1:0] pe;
    logic [15:0] mode_data, load_data, lv;
    logic [4:0] src, gate, tc, tog, arm, ex, m;
    logic [5*W-1:0] cnt, hold;
    int err_count = 0, comparisons = 0, cycles = 0;
    logic [7:0] mm [11] = '{8'hE8, 8'hEE, 8'hEF, 8'hF8, 8'hE0, 8'hE6,
        8'hE7, 8'hF9, 8'hE8, 8'hEE, 8'hFF};
    logic [3:0] mx [11] = '{4'h8, 4'hC, 4'hE, 4'hF, 4'h7, 4'h3, 4'h1,
        4'h0, 4'h8, 4'hC, 4'h0};
    host_model u_host_model (.clk_i(clk), .cmd_wr_o(cmd_wr),
        .cmd_data_o(cmd_data));
    ctr_gate_cmd u_ctr_gate_cmd (.CLK_I(clk), .RST_B_I(rst_b), .CE_I(ce),
        .CMD_WR_I(cmd_wr), .CMD_DATA_I(cmd_data), .MODE_WR_I(mode_wr),
        .MODE_SEL_I(mode_sel), .MODE_DATA_I(mode_data),
        .LOAD_WR_I(load_wr), .LOAD_DATA_I(load_data),
        .COUNT_SOURCE_PIN_I(src), .COUNTER_GATE_PIN_I(gate),
        .FREQ_TAP_I(5'h00), .COUNT_O(cnt), .HOLD_O(hold),
        .TERMINAL_COUNT_O(tc), .TOGGLE_O(tog), .ARMED_O(arm),
        .POINTER_ELEMENT_FIELD_O(pe), .POINTER_GROUP_FIELD_O(pg),
        .POINTER_SEQUENCING_DISABLE_O(psd), .FREQ_OUT_GATE_OFF_O(fog),
        .WIDE_BUS_SELECT_O(wbs), .PREFETCH_ENABLE_O(pfe));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Mode word: pin source 1, rising edge, repeat on
    function automatic logic [15:0] mode_w(input logic [2:0] g, input logic r);
        return {g, 1'b0, 4'h1, r, 1'b0, 1'b1, 5'h00};
    endfunction
    task automatic chk(input string n, input logic [15:0] s, e);
        comparisons++;
        if (s !== e) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic cmd(input logic [7:0] b);
        u_host_model.send(b);
        @(posedge clk);
        #1;
    endtask
    task automatic cfg(input logic [15:0] md, ld);
        @(posedge clk);
        mode_data <= md;
        load_data <= ld;
        mode_wr <= 1'b1;
        @(posedge clk);
        mode_wr <= 1'b0;
        load_wr <= 1'b1;
        @(posedge clk);
        load_wr <= 1'b0;
    endtask
    // Covers the pin synchroniser
    task automatic pin(input logic s, input logic g);
        @(posedge clk);
        src[0] <= s;
        gate[0] <= g;
        repeat (9) @(posedge clk);
        #1;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            test_done;
        end
    end
    initial begin
        {rst_b, mode_wr, load_wr, src, gate, mode_data, load_data} = '0;
        ce = 1'b1;
        mode_sel = 3'h1;
        void'($urandom(32'h240C8290));
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        foreach (mm[i]) begin
            cmd(mm[i]);
            chk("master bits", {psd, fog, wbs, pfe}, mx[i]);
        end
        for (int e = 0; e < 4; e++) begin
            lv = 16'($urandom % 5 + 1);
            cmd({3'h0, e[1:0], lv[2:0]});
            chk("pointer", {pe, pg}, {e[1:0], lv[2:0]});
        end
        ex = '0;
        repeat (6) begin
            m = 5'($urandom);
            cmd({3'h1, m});
            ex = ex | m;
            chk("armed", arm, ex);
            m = 5'($urandom);
            cmd({3'h6, m});
            ex = ex & ~m;
            chk("armed", arm, ex);
        end
        cmd(8'hDF);
        ex = '0;
        for (int n = 1; n <= 10; n++) begin
            m = 5'(1 << ((n - 1) % 5));
            cmd(n <= 5 ? 8'hE8 + 8'(n) : 8'hE0 + 8'(n - 5));
            ex = n <= 5 ? ex | m : ex & ~m;
            chk("toggle", tog, ex);
        end
        lv = 16'($urandom % 200 + 10);
        cfg(mode_w(ctr_pkg::GATE_NONE, 1'b0), lv);
        cmd(8'h41);
        chk("load", cnt[W-1:0], lv);
        cmd(8'h21);
        pin(1'b1, 1'b0);
        chk("rise", cnt[W-1:0], lv - 16'h1);
        pin(1'b0, 1'b0);
        chk("fall", cnt[W-1:0], lv - 16'h1);
        cmd(8'hF1);
        chk("step", cnt[W-1:0], lv - 16'h2);
        cmd(8'hA1);
        chk("save", hold[W-1:0], lv - 16'h2);
        cmd(8'hC1);
        pin(1'b1, 1'b0);
        chk("disarmed", cnt[W-1:0], lv - 16'h2);
        pin(1'b0, 1'b0);
        cfg(mode_w(ctr_pkg::GATE_OWN_HI, 1'b1), lv);
        cmd(8'h61);
        pin(1'b1, 1'b0);
        chk("gated off", cnt[W-1:0], lv);
        pin(1'b0, 1'b1);
        chk("retrig hold", hold[W-1:0], lv);
        pin(1'b1, 1'b1);
        chk("retrig load", cnt[W-1:0], lv);
        pin(1'b0, 1'b1);
        pin(1'b1, 1'b1);
        chk("gated on", cnt[W-1:0], lv - 16'h1);
        test_done;
    end
endmodule
`default_nettype wire
